// ### smai_array_model.sv
// Purpose: Storage array behind the module access block.
// Assumes: Row is ignored; bank and column pick the word.
// Notes: Unwritten words read back their own index.
`timescale 1ns/1ps
module smai_array_model (
  input wire logic CLK,
  input wire logic ARRAY_WE,
  input wire logic ARRAY_RE,
  input wire logic [1:0] ARRAY_BANK,
  input wire logic [8:0] ARRAY_COL,
  input wire logic [63:0] ARRAY_WDATA,
  input wire logic [7:0] ARRAY_MASK,
  output logic [63:0] ARRAY_RDATA
);
  logic [63:0] mem [0:2047];
  logic [10:0] idx;
  assign idx = {ARRAY_BANK, ARRAY_COL};
  // Inverted word when not read, so a late sample never passes
  assign ARRAY_RDATA = ARRAY_RE ? mem[idx] : ~mem[idx];
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 64'(i);
  end
  always @(posedge CLK) begin
    if (ARRAY_WE) begin
      for (int b = 0; b < 8; b++) begin
        if (!ARRAY_MASK[b]) mem[idx][8*b +: 8] <= ARRAY_WDATA[8*b +: 8];
      end
    end
  end
endmodule

// ### smai_id_store.sv
// Purpose: Package for the module access block, and the serial identity store.
// Assumes: SCL and SDA_I are synchronous to CLK and far slower than it.
// Notes: Identity store is 256 bytes behind a two-wire slave.
package smai_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned POWERUP_US = 100;
  localparam int unsigned POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int unsigned PRECHARGE_NS = 20;
  localparam int unsigned PRE_CYC = (PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] PRE_LOAD = 3'(PRE_CYC);
  // Register byte offsets
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_MODE = 5'h04;
  localparam logic [4:0] REG_BANKS = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  localparam int unsigned STATUS_FAULT_BIT = 8;
  localparam int unsigned MODE_OK_BIT = 16;
  // Capacity codes
  localparam logic [1:0] CAP_32 = 2'h0;
  localparam logic [1:0] CAP_128 = 2'h2;
  // Mode word fields
  localparam int unsigned BURST_COUNT_LSB = 0;
  localparam int unsigned BURST_ORDER_BIT = 3;
  localparam int unsigned READ_LATENCY_LSB = 4;
  localparam int unsigned OP_MODE_LOW_BIT = 7;
  localparam int unsigned OP_MODE_HIGH_BIT = 8;
  localparam int unsigned WRITE_SINGLE_BIT = 9;
  localparam int unsigned AUTO_PRE_BIT = 10;
  localparam logic [2:0] BURST_COUNT_1 = 3'h0;
  localparam logic [2:0] BURST_COUNT_2 = 3'h1;
  localparam logic [2:0] BURST_COUNT_4 = 3'h2;
  localparam logic [2:0] BURST_COUNT_8 = 3'h3;
  localparam logic [2:0] BURST_COUNT_PAGE = 3'h7;
  localparam logic [2:0] READ_LATENCY_2 = 3'h2;
  localparam logic [2:0] READ_LATENCY_3 = 3'h3;
  // Commands as {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_IDLE = 3'h7;
  localparam logic [1:0] INIT_REFRESHES = 2'h2;
  // Serial device type code
  localparam logic [3:0] ID_DEV_TYPE = 4'ha;
  typedef enum logic [2:0] {
    INIT_WAIT = 3'h0, INIT_PRE = 3'h1, INIT_REF = 3'h3, INIT_MODE = 3'h2, INIT_READY = 3'h6
  } smai_init_e;
  typedef enum logic [2:0] {
    ID_IDLE = 3'h0, ID_DEV = 3'h1, ID_ADDR = 3'h3, ID_DATA = 3'h2, ID_READ = 3'h6
  } smai_id_e;
endpackage

`timescale 1ns/1ps

module smai_id_store (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic [2:0] SA
);
  typedef struct packed {
    smai_pkg::smai_id_e st;
    logic scl_p;
    logic sda_p;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ackph;
    logic mack;
    logic oe_n;
  } smai_id_s;

  smai_id_s q, d;
  logic [7:0] mem [256];
  logic [7:0] rdata_q;
  logic mem_we;
  logic rise, fall, start, stop;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    mem_we = 1'b0;
    d.scl_p = SCL;
    d.sda_p = SDA_I;
    rise = SCL & ~q.scl_p;
    fall = ~SCL & q.scl_p;
    start = SCL & q.scl_p & q.sda_p & ~SDA_I;
    stop = SCL & q.scl_p & ~q.sda_p & SDA_I;
    if (start) begin
      d.st = smai_pkg::ID_DEV;
      d.bitc = 4'h0;
      d.ackph = 1'b0;
      d.oe_n = 1'b1;
    end else if (stop) begin
      d.st = smai_pkg::ID_IDLE;
      d.oe_n = 1'b1;
    end else if (q.st == smai_pkg::ID_READ) begin
      if (rise && q.ackph) begin
        d.mack = ~SDA_I;
      end
      if (fall) begin
        if (q.ackph) begin
          if (q.mack) begin
            d.sh = rdata_q;
            d.ptr = q.ptr + 8'h1;
            d.oe_n = rdata_q[7];
            d.bitc = 4'h1;
            d.ackph = 1'b0;
          end else begin
            d.st = smai_pkg::ID_IDLE;
            d.oe_n = 1'b1;
          end
        end else if (q.bitc == 4'h8) begin
          d.oe_n = 1'b1;
          d.ackph = 1'b1;
        end else begin
          d.sh = {q.sh[6:0], 1'b0};
          d.oe_n = q.sh[6];
          d.bitc = q.bitc + 4'h1;
        end
      end
    end else if (q.st != smai_pkg::ID_IDLE) begin
      if (rise && !q.ackph) begin
        d.sh = {q.sh[6:0], SDA_I};
        d.bitc = q.bitc + 4'h1;
      end
      if (fall && !q.ackph && q.bitc == 4'h8) begin
        d.ackph = 1'b1;
        d.oe_n = 1'b0;
        d.bitc = 4'h0;
        if (q.st == smai_pkg::ID_DEV && q.sh[7:1] != {smai_pkg::ID_DEV_TYPE, SA}) begin
          d.st = smai_pkg::ID_IDLE;
          d.ackph = 1'b0;
          d.oe_n = 1'b1;
        end else if (q.st == smai_pkg::ID_ADDR) begin
          d.ptr = q.sh;
        end else if (q.st == smai_pkg::ID_DATA) begin
          // No protect input exists, so every byte is writable
          mem_we = 1'b1;
          d.ptr = q.ptr + 8'h1;
        end
      end else if (fall && q.ackph) begin
        d.ackph = 1'b0;
        d.oe_n = 1'b1;
        if (q.st == smai_pkg::ID_DEV && q.sh[0]) begin
          d.st = smai_pkg::ID_READ;
          d.sh = rdata_q;
          d.ptr = q.ptr + 8'h1;
          d.oe_n = rdata_q[7];
          d.bitc = 4'h1;
        end else if (q.st == smai_pkg::ID_DEV) begin
          d.st = smai_pkg::ID_ADDR;
        end else begin
          d.st = smai_pkg::ID_DATA;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '{st: smai_pkg::ID_IDLE, scl_p: 1'b1, sda_p: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // Contents survive reset, as nonvolatile storage would
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[q.ptr] <= q.sh;
    end
    rdata_q <= mem[q.ptr];
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_N = q.oe_n;
endmodule

// ### smai_top.sv
// Purpose: Command-level model of a four-bank, 64-bit synchronous DRAM module.
// Assumes: Array storage lives outside, read combinationally from ARRAY_* outputs.
// Notes: Misuse by the controller sets a sticky fault bit instead of failing.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

module smai_top #(
  parameter int unsigned POWERUP_CYCLES = smai_pkg::POWERUP_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic BANK_SELECT_LOW,
  input wire logic BANK_SELECT_HIGH,
  input wire logic [12:0] ADDR,
  input wire logic [7:0] DQM,
  input wire logic [63:0] DQ_I,
  output logic [63:0] DQ_O,
  output logic [7:0] DQ_OE_N,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic [2:0] SA,
  output logic ARRAY_WE,
  output logic ARRAY_RE,
  output logic [1:0] ARRAY_BANK,
  output logic [12:0] ARRAY_ROW,
  output logic [8:0] ARRAY_COL,
  output logic [63:0] ARRAY_WDATA,
  output logic [7:0] ARRAY_MASK,
  input wire logic [63:0] ARRAY_RDATA,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  typedef struct packed {
    smai_pkg::smai_init_e init;
    logic [14:0] pu_cnt;
    logic pu_done;
    logic [1:0] ref_cnt;
    logic [11:0] mode;
    logic mode_ok;
    logic [1:0] cap;
    logic fault;
    logic [3:0] open;
    logic [3:0][12:0] row;
    logic [3:0][2:0] pcnt;
    logic b_act;
    logic b_wr;
    logic [1:0] b_bank;
    logic [8:0] b_base;
    logic [8:0] b_k;
    logic [8:0] b_mask;
    logic b_page;
    logic b_ilv;
    logic b_ap;
    logic a_we;
    logic a_re;
    logic [1:0] a_bank;
    logic [12:0] a_row;
    logic [8:0] a_col;
    logic [63:0] a_wd;
    logic [7:0] a_msk;
    logic rv;
    logic [63:0] st;
    logic [63:0] dq;
    logic [7:0] oe_n;
    logic [7:0] dqm;
    logic ack;
    logic [31:0] rd;
  } smai_core_s;

  smai_core_s q, d;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic [8:0] colmask, msk;
  logic [12:0] rowmask;
  logic [3:0] pbusy;
  logic all_idle, req, drive, rl3, bad_bl;
  logic [2:0] bl;
  logic [31:0] regval;

  // Column within an aligned block: sequential adds, interleaved xors
  function automatic logic [8:0] col_of(input logic [8:0] base, input logic [8:0] k,
                                        input logic [8:0] mask, input logic ilv);
    logic [8:0] off;
    off = ilv ? (base ^ k) : (base + k);
    return (base & ~mask) | (off & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  smai_id_store u_id (
    .CLK(CLK),
    .RST(RST),
    .SCL(SCL),
    .SDA_I(SDA_I),
    .SDA_O(SDA_O),
    .SDA_OE_N(SDA_OE_N),
    .SA(SA)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    cmd = CS_N ? smai_pkg::CMD_IDLE : {RAS_N, CAS_N, WE_N};
    bank = {BANK_SELECT_HIGH, BANK_SELECT_LOW};
    colmask = (q.cap == smai_pkg::CAP_32) ? 9'h0ff : 9'h1ff;
    rowmask = (q.cap == smai_pkg::CAP_128) ? 13'h1fff : 13'h0fff;
    for (int i = 0; i < 4; i++) begin
      pbusy[i] = q.pcnt[i] != 3'h0;
    end
    all_idle = (q.open == 4'h0) && (pbusy == 4'h0);
    rl3 = q.mode[smai_pkg::READ_LATENCY_LSB +: 3] != smai_pkg::READ_LATENCY_2;
    bl = q.mode[smai_pkg::BURST_COUNT_LSB +: 3];
    bad_bl = 1'b0;
    msk = 9'h0;
    case (bl)
      smai_pkg::BURST_COUNT_1: msk = 9'h0;
      smai_pkg::BURST_COUNT_2: msk = 9'h1;
      smai_pkg::BURST_COUNT_4: msk = 9'h3;
      smai_pkg::BURST_COUNT_8: msk = 9'h7;
      smai_pkg::BURST_COUNT_PAGE: msk = colmask;
      default: bad_bl = 1'b1;
    endcase
    // Bus: one wait cycle, then the answer; writes act on the answer edge
    req = AVS_READ | AVS_WRITE;
    d.ack = req & ~q.ack;
    regval = 32'h0;
    if (AVS_ADDRESS == smai_pkg::REG_CONFIG) begin
      regval = {30'h0, q.cap};
    end else if (AVS_ADDRESS == smai_pkg::REG_MODE) begin
      regval = {15'h0, q.mode_ok, 4'h0, q.mode};
    end else if (AVS_ADDRESS == smai_pkg::REG_BANKS) begin
      regval = {23'h0, q.b_act, pbusy, q.open};
    end else if (AVS_ADDRESS == smai_pkg::REG_STATUS) begin
      regval = {23'h0, q.fault, 3'h0, q.pu_done, 1'b0, q.init};
    end
    if (req && !q.ack) begin
      d.rd = regval;
    end
    if (AVS_WRITE && q.ack && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == smai_pkg::REG_CONFIG) begin
        d.cap = AVS_WRITEDATA[1:0];
      end else if (AVS_ADDRESS == smai_pkg::REG_STATUS) begin
        if (AVS_WRITEDATA[smai_pkg::STATUS_FAULT_BIT]) begin
          d.fault = 1'b0;
        end
      end
    end
    // Power-up wait
    if (!q.pu_done) begin
      d.pu_cnt = q.pu_cnt + 15'h1;
      if (q.pu_cnt == 15'(POWERUP_CYCLES - 1)) begin
        d.pu_done = 1'b1;
      end
      if (cmd != smai_pkg::CMD_IDLE) begin
        d.fault = 1'b1;
      end
    end
    // Each bank times its own precharge, so others stay usable
    for (int i = 0; i < 4; i++) begin
      if (pbusy[i]) begin
        d.pcnt[i] = q.pcnt[i] - 3'h1;
      end
    end
    // Burst continuation, one column per clock
    d.a_we = 1'b0;
    d.a_re = 1'b0;
    if (q.b_act) begin
      d.a_we = q.b_wr;
      d.a_re = ~q.b_wr;
      d.a_bank = q.b_bank;
      d.a_row = q.row[q.b_bank];
      d.a_col = col_of(q.b_base, q.b_k, q.b_mask, q.b_ilv);
      d.a_wd = DQ_I;
      d.a_msk = DQM;
      d.b_k = (q.b_k + 9'h1) & q.b_mask;
      if (q.b_k == q.b_mask && !q.b_page) begin
        d.b_act = 1'b0;
        if (q.b_ap) begin
          d.open[q.b_bank] = 1'b0;
          d.pcnt[q.b_bank] = smai_pkg::PRE_LOAD;
        end
      end
    end
    if (cmd != smai_pkg::CMD_IDLE && cmd != smai_pkg::CMD_LMR && cmd != smai_pkg::CMD_REF
        && cmd != smai_pkg::CMD_PRE && !q.mode_ok) begin
      d.fault = 1'b1;
    end
    case (cmd)
      smai_pkg::CMD_ACT: begin
        if (q.open[bank] || pbusy[bank]) begin
          d.fault = 1'b1;
        end else begin
          d.open[bank] = 1'b1;
          d.row[bank] = ADDR & rowmask;
        end
      end
      smai_pkg::CMD_READ, smai_pkg::CMD_WRITE: begin
        if (!q.open[bank]) begin
          d.fault = 1'b1;
        end else begin
          if (bad_bl || q.mode[smai_pkg::OP_MODE_LOW_BIT] || q.mode[smai_pkg::OP_MODE_HIGH_BIT]
              || (bl == smai_pkg::BURST_COUNT_PAGE && q.mode[smai_pkg::BURST_ORDER_BIT])) begin
            d.fault = 1'b1;
          end
          d.b_wr = ~WE_N;
          if (~WE_N && q.mode[smai_pkg::WRITE_SINGLE_BIT]) begin
            msk = 9'h0;
          end
          // A fresh column command replaces any burst in flight
          d.b_bank = bank;
          d.b_base = ADDR[8:0] & colmask;
          d.b_mask = msk;
          d.b_k = 9'h1 & msk;
          d.b_page = (bl == smai_pkg::BURST_COUNT_PAGE) && (msk != 9'h0);
          d.b_ilv = q.mode[smai_pkg::BURST_ORDER_BIT] && !d.b_page;
          d.b_ap = ADDR[smai_pkg::AUTO_PRE_BIT];
          d.b_act = msk != 9'h0;
          d.a_we = ~WE_N;
          d.a_re = WE_N;
          d.a_bank = bank;
          d.a_row = q.row[bank];
          d.a_col = ADDR[8:0] & colmask;
          d.a_wd = DQ_I;
          d.a_msk = DQM;
          if (msk == 9'h0 && ADDR[smai_pkg::AUTO_PRE_BIT]) begin
            d.open[bank] = 1'b0;
            d.pcnt[bank] = smai_pkg::PRE_LOAD;
          end
        end
      end
      smai_pkg::CMD_BST: d.b_act = 1'b0;
      smai_pkg::CMD_PRE: begin
        for (int i = 0; i < 4; i++) begin
          if ((ADDR[smai_pkg::AUTO_PRE_BIT] || bank == 2'(i)) && q.open[i]) begin
            d.open[i] = 1'b0;
            d.pcnt[i] = smai_pkg::PRE_LOAD;
            if (q.b_act && q.b_bank == 2'(i)) begin
              d.b_act = 1'b0;
            end
          end
        end
        if (q.init == smai_pkg::INIT_PRE && ADDR[smai_pkg::AUTO_PRE_BIT]) begin
          d.init = smai_pkg::INIT_REF;
        end
      end
      smai_pkg::CMD_REF: begin
        if (!all_idle) begin
          d.fault = 1'b1;
        end else if (q.init == smai_pkg::INIT_REF) begin
          d.ref_cnt = q.ref_cnt + 2'h1;
          if (q.ref_cnt + 2'h1 == smai_pkg::INIT_REFRESHES) begin
            d.init = smai_pkg::INIT_MODE;
          end
        end
      end
      smai_pkg::CMD_LMR: begin
        if (!all_idle) begin
          d.fault = 1'b1;
        end else begin
          d.mode = ADDR[11:0];
          d.mode_ok = 1'b1;
          if (q.init == smai_pkg::INIT_MODE) begin
            d.init = smai_pkg::INIT_READY;
          end
        end
      end
      default: d.fault = d.fault;
    endcase
    if (q.init == smai_pkg::INIT_WAIT && q.pu_done) begin
      d.init = smai_pkg::INIT_PRE;
    end
    // Read return: latency 2 drives straight from the array, 3 adds a stage
    d.rv = q.a_re;
    d.st = ARRAY_RDATA;
    drive = rl3 ? q.rv : q.a_re;
    if (drive) begin
      d.dq = rl3 ? q.st : ARRAY_RDATA;
    end
    // Mask seen one edge earlier gives the two-clock turn-off
    d.oe_n = {8{~drive}} | q.dqm;
    d.dqm = DQM;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= '{init: smai_pkg::INIT_WAIT, cap: smai_pkg::CONFIG_RESET, oe_n: 8'hff, default: '0};
    end else begin
      q <= d;
    end
  end

  assign DQ_O = q.dq;
  assign DQ_OE_N = q.oe_n;
  assign ARRAY_WE = q.a_we;
  assign ARRAY_RE = q.a_re;
  assign ARRAY_BANK = q.a_bank;
  assign ARRAY_ROW = q.a_row;
  assign ARRAY_COL = q.a_col;
  assign ARRAY_WDATA = q.a_wd;
  assign ARRAY_MASK = q.a_msk;
  assign AVS_READDATA = q.rd;
  assign AVS_WAITREQUEST = req & ~q.ack;
endmodule

// ### smai_top_properties.sv
// Purpose: Port-level properties of the module access block.
// Assumes: DQM stays low during reads; no closed-bank read mid-burst.
// Notes: Bound to the top module by name.
`timescale 1ns/1ps
module smai_top_chk #(
  parameter int unsigned POWERUP_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic BANK_SELECT_LOW,
  input wire logic BANK_SELECT_HIGH,
  input wire logic [12:0] ADDR,
  input wire logic [7:0] DQM,
  input wire logic [63:0] DQ_I,
  input wire logic [7:0] DQ_OE_N,
  input wire logic SDA_O,
  input wire logic ARRAY_WE,
  input wire logic ARRAY_RE,
  input wire logic [1:0] ARRAY_BANK,
  input wire logic [8:0] ARRAY_COL,
  input wire logic [63:0] ARRAY_WDATA,
  input wire logic [7:0] ARRAY_MASK,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST
);
  logic rd_cmd, wr_cmd, bus_req;
  logic [1:0] bank_w;
  logic [7:0] col_w;
  assign rd_cmd = !CS_N && ({RAS_N, CAS_N, WE_N} == smai_pkg::CMD_READ);
  assign wr_cmd = !CS_N && ({RAS_N, CAS_N, WE_N} == smai_pkg::CMD_WRITE);
  assign bus_req = AVS_READ || AVS_WRITE;
  assign bank_w = {BANK_SELECT_HIGH, BANK_SELECT_LOW};
  assign col_w = ADDR[7:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  chk_one_wait: assert property (bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus wait longer than one cycle");
  chk_idle_nowait: assert property (!bus_req |-> !AVS_WAITREQUEST)
    else $error("wait raised with no request");
  chk_rdata_hold: assert property (!bus_req |=> $stable(AVS_READDATA))
    else $error("read data changed without request");
  chk_re_cause: assert property ($rose(ARRAY_RE) |-> $past(rd_cmd))
    else $error("array read without read command");
  chk_we_cause: assert property ($rose(ARRAY_WE) |-> $past(wr_cmd))
    else $error("array write without write command");
  chk_wdata_path: assert property (ARRAY_WE |-> ARRAY_WDATA == $past(DQ_I) && ARRAY_MASK == $past(DQM))
    else $error("write beat data or mask wrong");
  chk_start_col: assert property (ARRAY_RE && $past(rd_cmd) |->
    ARRAY_COL[7:0] == $past(col_w) && ARRAY_BANK == $past(bank_w))
    else $error("first read beat at wrong place");
  chk_oe_latency: assert property ($fell(DQ_OE_N[0]) |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
    else $error("output enabled at wrong latency");
  chk_sda_low: assert property (SDA_O == 1'b0)
    else $error("serial data not open drain");
  cover property (rd_cmd ##1 ARRAY_RE [*4]);
  cover property (wr_cmd ##1 ARRAY_WE);
  cover property (bus_req && !AVS_WAITREQUEST);
endmodule
bind smai_top smai_top_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) smai_top_chk_inst (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
  .BANK_SELECT_LOW(BANK_SELECT_LOW), .BANK_SELECT_HIGH(BANK_SELECT_HIGH), .ADDR(ADDR),
  .DQM(DQM), .DQ_I(DQ_I), .DQ_OE_N(DQ_OE_N), .SDA_O(SDA_O), .ARRAY_WE(ARRAY_WE),
  .ARRAY_RE(ARRAY_RE), .ARRAY_BANK(ARRAY_BANK), .ARRAY_COL(ARRAY_COL),
  .ARRAY_WDATA(ARRAY_WDATA), .ARRAY_MASK(ARRAY_MASK), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
);

// ### smai_top_tb.sv
// Purpose: Self-checking bench for the module access block.
// Assumes: Power-up wait shortened to 20 cycles.
// Notes: Identity store is written once and read back.
`timescale 1ns/1ps
module smai_top_tb;
  logic CLK, RST, CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT_LOW, BANK_SELECT_HIGH;
  logic [12:0] ADDR, ARRAY_ROW;
  logic [7:0] DQM, DQ_OE_N, ARRAY_MASK;
  logic [63:0] DQ_I, DQ_O, ARRAY_WDATA, ARRAY_RDATA;
  logic SDA_O, SDA_OE_N, ARRAY_WE, ARRAY_RE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic SCL, SDA_I, sda_m;
  logic [1:0] ARRAY_BANK;
  logic [8:0] ARRAY_COL;
  logic [4:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  int n_errors = 0;
  int checks_done = 0;
  smai_top #(.POWERUP_CYCLES(20)) smai_top_inst (
    .CLK(CLK), .RST(RST), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
    .BANK_SELECT_LOW(BANK_SELECT_LOW), .BANK_SELECT_HIGH(BANK_SELECT_HIGH), .ADDR(ADDR),
    .DQM(DQM), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .SCL(SCL), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .SA(3'h0), .ARRAY_WE(ARRAY_WE), .ARRAY_RE(ARRAY_RE),
    .ARRAY_BANK(ARRAY_BANK), .ARRAY_ROW(ARRAY_ROW), .ARRAY_COL(ARRAY_COL),
    .ARRAY_WDATA(ARRAY_WDATA), .ARRAY_MASK(ARRAY_MASK), .ARRAY_RDATA(ARRAY_RDATA),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST)
  );
  smai_array_model smai_array_model_inst (
    .CLK(CLK), .ARRAY_WE(ARRAY_WE), .ARRAY_RE(ARRAY_RE), .ARRAY_BANK(ARRAY_BANK),
    .ARRAY_COL(ARRAY_COL), .ARRAY_WDATA(ARRAY_WDATA), .ARRAY_MASK(ARRAY_MASK),
    .ARRAY_RDATA(ARRAY_RDATA)
  );
  // Wired-and serial data line
  assign SDA_I = sda_m & (SDA_OE_N | SDA_O);
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a);
    @(posedge CLK);
    CS_N <= (c == smai_pkg::CMD_IDLE);
    {RAS_N, CAS_N, WE_N} <= c;
    {BANK_SELECT_HIGH, BANK_SELECT_LOW} <= ba;
    ADDR <= a;
  endtask
  task automatic idle(input int n);
    repeat (n) issue(smai_pkg::CMD_IDLE, 2'h0, 13'h0000);
  endtask
  // Bus wait is bounded; waitrequest is read 1 ns after each edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic w;
    int n = 0;
    @(posedge CLK);
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do begin
      #1 w = AVS_WAITREQUEST;
      @(posedge CLK);
      n++;
    end while (w && n < 50);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (w) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic rdreg(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, {32'h0, exp}, {32'h0, q});
  endtask
  task automatic read_chk(input logic [1:0] ba, input logic [12:0] a, input int lat,
                          input int n, input logic [63:0] exp [8]);
    issue(smai_pkg::CMD_READ, ba, a);
    idle(1);
    repeat (lat - 2) begin
      @(posedge CLK);
      #1 check("oe_early", 64'hff, {56'h0, DQ_OE_N});
    end
    for (int k = 0; k < n; k++) begin
      @(posedge CLK);
      #1 check("dq_o", exp[k], DQ_O);
      check("oe_on", 64'h0, {56'h0, DQ_OE_N});
    end
    @(posedge CLK);
    #1 check("oe_off", 64'hff, {56'h0, DQ_OE_N});
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sda_m <= b;
    repeat (4) @(posedge CLK);
    SCL <= 1'b1;
    repeat (4) @(posedge CLK);
    r = SDA_I;
    SCL <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task automatic i2c_start();
    sda_m <= 1'b1;
    SCL <= 1'b1;
    repeat (4) @(posedge CLK);
    sda_m <= 1'b0;
    repeat (4) @(posedge CLK);
    SCL <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic chk, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(1'b1, a);
    if (chk) check("id_ack", 64'h0, {63'h0, a});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    rdreg(smai_pkg::REG_STATUS, 32'h00, "status_waiting");
    idle(25);
    rdreg(smai_pkg::REG_STATUS, 32'h11, "status_waited");
    $display("test powerup done");
  endtask
  task automatic t_init();
    logic [31:0] q;
    issue(smai_pkg::CMD_PRE, 2'h0, 13'h0400);
    idle(5);
    rdreg(smai_pkg::REG_STATUS, 32'h13, "status_refresh");
    for (int k = 0; k < 2; k++) begin
      issue(smai_pkg::CMD_REF, 2'h0, 13'h0000);
      idle(3);
    end
    rdreg(smai_pkg::REG_STATUS, 32'h12, "status_mode");
    issue(smai_pkg::CMD_LMR, 2'h0, 13'h0022);
    idle(3);
    bus(1'b1, smai_pkg::REG_MODE, 32'h0, q);
    rdreg(smai_pkg::REG_MODE, 32'h10022, "mode_word");
    rdreg(smai_pkg::REG_STATUS, 32'h16, "status_ready");
    rdreg(5'h10, 32'h0, "unmapped");
    bus(1'b1, smai_pkg::REG_CONFIG, 32'(smai_pkg::CAP_128), q);
    rdreg(smai_pkg::REG_CONFIG, 32'(smai_pkg::CAP_128), "config");
    $display("test init done");
  endtask
  task automatic t_write_wrap();
    logic [63:0] e [8];
    logic [63:0] r [8];
    issue(smai_pkg::CMD_ACT, 2'h1, 13'h0003);
    for (int k = 0; k < 4; k++) begin
      if (k == 0) issue(smai_pkg::CMD_WRITE, 2'h1, 13'h0006);
      else issue(smai_pkg::CMD_IDLE, 2'h0, 13'h0000);
      DQ_I <= 64'ha5a5_0000_0000_0000 | 64'(k);
      e[(2 + k) % 4] = 64'ha5a5_0000_0000_0000 | 64'(k);
    end
    idle(1);
    for (int k = 0; k < 4; k++) r[k] = e[(1 + k) % 4];
    read_chk(2'h1, 13'h0005, 2, 4, r);
    $display("test write_wrap done");
  endtask
  task automatic t_interleave();
    logic [63:0] e [8];
    int ofs [8] = '{5, 4, 7, 6, 1, 0, 3, 2};
    issue(smai_pkg::CMD_PRE, 2'h1, 13'h0000);
    idle(6);
    issue(smai_pkg::CMD_LMR, 2'h0, 13'h003b);
    idle(3);
    issue(smai_pkg::CMD_ACT, 2'h2, 13'h0001);
    idle(1);
    for (int k = 0; k < 8; k++) e[k] = 64'h400 + 64'(8 + ofs[k]);
    read_chk(2'h2, 13'h000d, 3, 8, e);
    $display("test interleave done");
  endtask
  task automatic t_closed_bank();
    logic [31:0] q;
    issue(smai_pkg::CMD_READ, 2'h3, 13'h0000);
    idle(1);
    repeat (4) begin
      @(posedge CLK);
      #1 check("array_re", 64'h0, {63'h0, ARRAY_RE});
    end
    check("array_row", 64'h1, {51'h0, ARRAY_ROW});
    rdreg(smai_pkg::REG_STATUS, 32'h116, "fault_set");
    bus(1'b1, smai_pkg::REG_STATUS, 32'h100, q);
    rdreg(smai_pkg::REG_STATUS, 32'h16, "fault_clear");
    $display("test closed_bank done");
  endtask
  task automatic t_identity();
    logic [7:0] rx;
    i2c_start();
    i2c_byte({smai_pkg::ID_DEV_TYPE, 4'h0}, 1'b1, rx);
    i2c_byte(8'h80, 1'b1, rx);
    i2c_byte(8'h5c, 1'b1, rx);
    i2c_start();
    i2c_byte({smai_pkg::ID_DEV_TYPE, 4'h0}, 1'b1, rx);
    i2c_byte(8'h80, 1'b1, rx);
    i2c_start();
    i2c_byte({smai_pkg::ID_DEV_TYPE, 4'h1}, 1'b1, rx);
    i2c_byte(8'hff, 1'b0, rx);
    check("id_byte", 64'h5c, {56'h0, rx});
    $display("test identity done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    end_of_test();
  end
  initial begin
    RST = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
    {BANK_SELECT_HIGH, BANK_SELECT_LOW} = 2'h0;
    ADDR = 13'h0000;
    DQM = 8'h00;
    DQ_I = 64'h0;
    {AVS_READ, AVS_WRITE} = 2'h0;
    AVS_ADDRESS = 5'h00;
    AVS_WRITEDATA = 32'h0;
    {SCL, sda_m} = 2'h3;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    t_powerup();
    t_init();
    t_write_wrap();
    t_interleave();
    t_closed_bank();
    t_identity();
    end_of_test();
  end
endmodule
